//--- inc/lmsu_pkg.sv
// constants and types for the lin master/slave serial port
// assumes a 100 MHz clk and a 16x oversampling baud tick
package lmsu_pkg;
    localparam int AW = 4;
    localparam int DW = 16;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_BAUD = 4'h1;
    localparam logic [3:0] A_RLEN = 4'h2;
    localparam logic [3:0] A_HDR = 4'h3;
    localparam logic [3:0] A_TXD = 4'h4;
    localparam logic [3:0] A_RXD = 4'h5;
    localparam logic [3:0] A_STAT = 4'h6;
    localparam logic [3:0] A_IFLAG = 4'h7;
    localparam logic [3:0] A_IMASK = 4'h8;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int C_TX_PATH_ENABLE = 4;
    localparam int C_RX_PATH_ENABLE = 5;
    localparam int C_ON = 6;
    localparam int C_POL = 7;
    localparam int C_STP = 8;
    localparam int C_CSM = 9;
    localparam logic [3:0] MODE_LIN = 4'hc;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [3:0] RLEN_RST = 4'h0;
    // ------------------------------------------------------------
    // interrupt flag positions
    // ------------------------------------------------------------
    localparam int IW = 4;
    localparam int I_CERR = 0;
    localparam int I_RXB = 1;
    localparam int I_HDR = 2;
    localparam int I_RSP = 3;
    // ------------------------------------------------------------
    // bit timing
    // ------------------------------------------------------------
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] BREAK_BITS = 4'hd;
    localparam logic [3:0] DELIM_BITS = 4'h1;
    localparam logic [3:0] FRAME_1STOP = 4'ha;
    localparam logic [3:0] FRAME_2STOP = 4'hb;
    localparam logic [7:0] SYNC_BYTE = 8'h55;
    localparam logic [7:0] SUM_OK = 8'hff;

    typedef enum logic [1:0] {TX_IDLE, TX_BREAK, TX_DELIM, TX_BYTE} lmsu_tx_t;
    typedef enum logic [1:0] {K_SYNC, K_PID, K_DATA, K_CHK} lmsu_kind_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HIGH} lmsu_rx_t;
    typedef enum logic [1:0] {F_BREAK, F_SYNC, F_PID, F_DATA} lmsu_fr_t;
endpackage

//--- core/lmsu_tick.sv
// baud divider: one-cycle sample tick every div+1 clocks
// assumes div is held steady while the port is on
`timescale 1ns/1ps
`default_nettype none
module lmsu_tick #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] div,
    output logic tick
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (rst || !en) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= div) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick = en && (cnt_reg >= div);
endmodule
`default_nettype wire

//--- core/lmsu_core.sv
// lin master/slave serial port: header generator, response checksum
// assumes a plain register port and a transceiver on rx_in / tx_out
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lmsu_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic [lmsu_pkg::AW-1:0] addr,
    input wire logic [lmsu_pkg::DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [lmsu_pkg::DW-1:0] rdata,
    input wire logic rx_in,
    output logic tx_out,
    output logic irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] ctrl_reg, baud_reg;
    logic [3:0] rlen_reg;
    logic [lmsu_pkg::IW-1:0] iflag_reg, imask_reg, iset;
    logic [15:0] rdata_reg;
    logic stick, lin_ok, rx_on, csm, hdr_wr, txd_wr;

    assign csm = ctrl_reg[lmsu_pkg::C_CSM];
    assign lin_ok = ctrl_reg[3:0] == lmsu_pkg::MODE_LIN && ctrl_reg[lmsu_pkg::C_ON]
        && ctrl_reg[lmsu_pkg::C_TX_PATH_ENABLE];
    assign rx_on = ctrl_reg[lmsu_pkg::C_ON] && ctrl_reg[lmsu_pkg::C_RX_PATH_ENABLE];
    assign hdr_wr = wr_stb && addr == lmsu_pkg::A_HDR;
    assign txd_wr = wr_stb && addr == lmsu_pkg::A_TXD;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= lmsu_pkg::CTRL_RST;
            baud_reg <= lmsu_pkg::BAUD_RST;
            rlen_reg <= lmsu_pkg::RLEN_RST;
            imask_reg <= '0;
        end else if (wr_stb) begin
            if (addr == lmsu_pkg::A_CTRL) ctrl_reg <= wdata;
            if (addr == lmsu_pkg::A_BAUD) baud_reg <= wdata;
            if (addr == lmsu_pkg::A_RLEN) rlen_reg <= wdata[3:0];
            if (addr == lmsu_pkg::A_IMASK) imask_reg <= wdata[lmsu_pkg::IW-1:0];
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            iflag_reg <= '0;
        end else if (wr_stb && addr == lmsu_pkg::A_IFLAG) begin
            iflag_reg <= (iflag_reg & ~wdata[lmsu_pkg::IW-1:0]) | iset;
        end else begin
            iflag_reg <= iflag_reg | iset;
        end
    end

    assign irq = |(iflag_reg & imask_reg);

    lmsu_tick #(.W(16)) u_tick (
        .clk(clk),
        .rst(rst),
        .en(ctrl_reg[lmsu_pkg::C_ON]),
        .div(baud_reg),
        .tick(stick)
    );

    // ones-complement add with end-around carry
    function automatic logic [7:0] lsum(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        lsum = s[7:0] + {7'h00, s[8]};
    endfunction

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    lmsu_pkg::lmsu_tx_t st;
    lmsu_pkg::lmsu_kind_t kind;
    logic [3:0] ph, n, nbits, tcnt, brk_bits;
    logic [10:0] sh;
    logic [7:0] tbuf, tsum, hpid, rx_pid, tx_total;
    logic line, tbuf_full, chk_pend, hdr_done, resp_done, bit_end, pid_evt;

    assign nbits = ctrl_reg[lmsu_pkg::C_STP] ? lmsu_pkg::FRAME_2STOP : lmsu_pkg::FRAME_1STOP;
    assign bit_end = stick && ph == lmsu_pkg::OVS_LAST;
    assign tx_total = lsum(tsum, csm ? rx_pid : 8'h00);

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= lmsu_pkg::TX_IDLE;
            kind <= lmsu_pkg::K_SYNC;
            ph <= '0;
            n <= '0;
            sh <= '1;
            line <= 1'b1;
            tbuf <= '0;
            tbuf_full <= 1'b0;
            hpid <= '0;
            tsum <= '0;
            tcnt <= '0;
            chk_pend <= 1'b0;
            hdr_done <= 1'b0;
            resp_done <= 1'b0;
        end else begin
            hdr_done <= 1'b0;
            resp_done <= 1'b0;
            if (txd_wr && !tbuf_full) begin
                tbuf <= wdata[7:0];
                tbuf_full <= 1'b1;
            end
            if (pid_evt) begin
                tsum <= '0;
                tcnt <= '0;
                chk_pend <= 1'b0;
            end
            if (st != lmsu_pkg::TX_IDLE && stick) ph <= ph + 1'b1;
            unique case (st)
                lmsu_pkg::TX_IDLE: begin
                    line <= 1'b1;
                    ph <= '0;
                    n <= '0;
                    if (hdr_wr && lin_ok) begin
                        hpid <= wdata[7:0];
                        st <= lmsu_pkg::TX_BREAK;
                    end else if (lin_ok && tbuf_full) begin
                        sh <= {2'b11, tbuf, 1'b0};
                        tsum <= lsum(tsum, tbuf);
                        tcnt <= tcnt + 1'b1;
                        chk_pend <= (tcnt + 1'b1) == rlen_reg;
                        tbuf_full <= 1'b0;
                        kind <= lmsu_pkg::K_DATA;
                        st <= lmsu_pkg::TX_BYTE;
                    end else if (lin_ok && chk_pend) begin
                        sh <= {2'b11, ~tx_total, 1'b0};
                        chk_pend <= 1'b0;
                        kind <= lmsu_pkg::K_CHK;
                        st <= lmsu_pkg::TX_BYTE;
                    end
                end
                lmsu_pkg::TX_BREAK: begin
                    line <= 1'b0;
                    if (bit_end) begin
                        n <= n + 1'b1;
                        if (n == lmsu_pkg::BREAK_BITS - 1'b1) begin
                            n <= '0;
                            st <= lmsu_pkg::TX_DELIM;
                        end
                    end
                end
                lmsu_pkg::TX_DELIM: begin
                    line <= 1'b1;
                    if (bit_end) begin
                        n <= n + 1'b1;
                        if (n == lmsu_pkg::DELIM_BITS - 1'b1) begin
                            n <= '0;
                            sh <= {2'b11, lmsu_pkg::SYNC_BYTE, 1'b0};
                            kind <= lmsu_pkg::K_SYNC;
                            st <= lmsu_pkg::TX_BYTE;
                        end
                    end
                end
                lmsu_pkg::TX_BYTE: begin
                    line <= sh[0];
                    if (bit_end) begin
                        sh <= {1'b1, sh[10:1]};
                        n <= n + 1'b1;
                        if (n == nbits - 1'b1) begin
                            n <= '0;
                            if (kind == lmsu_pkg::K_SYNC) begin
                                sh <= {2'b11, hpid, 1'b0};
                                kind <= lmsu_pkg::K_PID;
                            end else begin
                                st <= lmsu_pkg::TX_IDLE;
                                hdr_done <= kind == lmsu_pkg::K_PID;
                                resp_done <= kind == lmsu_pkg::K_CHK;
                            end
                        end
                    end
                end
            endcase
            // dropping the port mid-frame abandons the frame
            if (!lin_ok) st <= lmsu_pkg::TX_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_out <= 1'b1;
        end else begin
            tx_out <= line ^ ctrl_reg[lmsu_pkg::C_POL];
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    lmsu_pkg::lmsu_rx_t rst_st;
    lmsu_pkg::lmsu_fr_t fr;
    logic rx_s1, rx_s2;
    logic [3:0] rph, rn, rcnt;
    logic [7:0] rsh, rxd_reg, rsum, rx_total;
    logic byte_evt, brk_evt, chk_evt, cerr;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= rx_in;
            rx_s2 <= rx_s1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rst_st <= lmsu_pkg::RX_IDLE;
            rph <= '0;
            rn <= '0;
            rsh <= '0;
            byte_evt <= 1'b0;
            brk_evt <= 1'b0;
        end else begin
            byte_evt <= 1'b0;
            brk_evt <= 1'b0;
            if (stick) rph <= rph + 1'b1;
            unique case (rst_st)
                lmsu_pkg::RX_IDLE: begin
                    rph <= '0;
                    if (!rx_s2) rst_st <= lmsu_pkg::RX_START;
                end
                lmsu_pkg::RX_START: begin
                    if (stick && rph == lmsu_pkg::OVS_MID) begin
                        rph <= '0;
                        rn <= '0;
                        rst_st <= rx_s2 ? lmsu_pkg::RX_IDLE : lmsu_pkg::RX_DATA;
                    end
                end
                lmsu_pkg::RX_DATA: begin
                    if (stick && rph == lmsu_pkg::OVS_LAST) begin
                        rsh <= {rx_s2, rsh[7:1]};
                        rn <= rn + 1'b1;
                        if (rn == 4'h7) rst_st <= lmsu_pkg::RX_STOP;
                    end
                end
                lmsu_pkg::RX_STOP: begin
                    if (stick && rph == lmsu_pkg::OVS_LAST) begin
                        byte_evt <= rx_s2;
                        brk_evt <= !rx_s2 && rsh == 8'h00;
                        rst_st <= rx_s2 ? lmsu_pkg::RX_IDLE : lmsu_pkg::RX_HIGH;
                    end
                end
                lmsu_pkg::RX_HIGH: begin
                    if (rx_s2) rst_st <= lmsu_pkg::RX_IDLE;
                end
            endcase
            if (!rx_on) rst_st <= lmsu_pkg::RX_IDLE;
        end
    end

    // the receiver hears every header on the bus, our own included
    assign rx_total = lsum(lsum(rsum, csm ? rx_pid : 8'h00), rsh);
    assign pid_evt = byte_evt && fr == lmsu_pkg::F_PID;
    assign chk_evt = byte_evt && fr == lmsu_pkg::F_DATA && rcnt == rlen_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            fr <= lmsu_pkg::F_BREAK;
            rx_pid <= '0;
            rxd_reg <= '0;
            rsum <= '0;
            rcnt <= '0;
            cerr <= 1'b0;
        end else begin
            cerr <= chk_evt && rx_total != lmsu_pkg::SUM_OK;
            if (byte_evt) rxd_reg <= rsh;
            if (brk_evt) begin
                fr <= lmsu_pkg::F_SYNC;
            end else if (byte_evt) begin
                unique case (fr)
                    lmsu_pkg::F_BREAK: fr <= lmsu_pkg::F_BREAK;
                    lmsu_pkg::F_SYNC: begin
                        fr <= rsh == lmsu_pkg::SYNC_BYTE ? lmsu_pkg::F_PID : lmsu_pkg::F_BREAK;
                    end
                    lmsu_pkg::F_PID: begin
                        rx_pid <= rsh;
                        rsum <= '0;
                        rcnt <= '0;
                        fr <= lmsu_pkg::F_DATA;
                    end
                    lmsu_pkg::F_DATA: begin
                        if (chk_evt) begin
                            fr <= lmsu_pkg::F_BREAK;
                        end else begin
                            rsum <= lsum(rsum, rsh);
                            rcnt <= rcnt + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    always_comb begin
        iset = '0;
        iset[lmsu_pkg::I_CERR] = cerr;
        iset[lmsu_pkg::I_RXB] = byte_evt;
        iset[lmsu_pkg::I_HDR] = hdr_done;
        iset[lmsu_pkg::I_RSP] = resp_done;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (rd_stb) begin
            unique case (addr)
                lmsu_pkg::A_CTRL: rdata_reg <= ctrl_reg;
                lmsu_pkg::A_BAUD: rdata_reg <= baud_reg;
                lmsu_pkg::A_RLEN: rdata_reg <= {12'h000, rlen_reg};
                lmsu_pkg::A_RXD: rdata_reg <= {8'h00, rxd_reg};
                lmsu_pkg::A_STAT: rdata_reg <= {10'h000, fr, chk_pend, tbuf_full,
                    rst_st != lmsu_pkg::RX_IDLE, st != lmsu_pkg::TX_IDLE};
                lmsu_pkg::A_IFLAG: rdata_reg <= {12'h000, iflag_reg};
                lmsu_pkg::A_IMASK: rdata_reg <= {12'h000, imask_reg};
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    always_ff @(posedge clk) begin
        if (rst || st == lmsu_pkg::TX_IDLE) brk_bits <= '0;
        else if (st == lmsu_pkg::TX_BREAK && bit_end) brk_bits <= brk_bits + 1'b1;
    end

    brk_len_a: assert property ($fell(st == lmsu_pkg::TX_BREAK) && lin_ok
        |-> brk_bits == lmsu_pkg::BREAK_BITS) else $error("break length wrong");
    hdr_order_a: assert property ($rose(st == lmsu_pkg::TX_DELIM)
        |-> $past(st) == lmsu_pkg::TX_BREAK) else $error("delimiter without break");
    sync_next_a: assert property (st == lmsu_pkg::TX_DELIM ##1 st == lmsu_pkg::TX_BYTE
        |-> kind == lmsu_pkg::K_SYNC && sh[8:1] == lmsu_pkg::SYNC_BYTE)
        else $error("sync field not after delimiter");
    idle_after_a: assert property (hdr_done && !tbuf_full && !chk_pend
        |=> line [*2]) else $error("line not idle after header");
    tx_chk_a: assert property (st == lmsu_pkg::TX_IDLE && lin_ok && !tbuf_full
        && chk_pend && !hdr_wr |=> sh[8:1] == ~$past(tx_total))
        else $error("appended checksum wrong");
    rx_chk_a: assert property (chk_evt && rx_total != lmsu_pkg::SUM_OK
        |=> ##1 iflag_reg[lmsu_pkg::I_CERR]) else $error("checksum error not flagged");
    legacy_sum_a: assert property (chk_evt && !csm
        |-> rx_total == lsum(rsum, rsh)) else $error("legacy sum includes id");
    resp_reset_a: assert property (pid_evt
        |=> tcnt == 4'h0 && !chk_pend) else $error("response state kept over header");

    hdr_c: cover property (hdr_done);
    rsp_c: cover property (resp_done);
    cerr_c: cover property (cerr);
endmodule
`default_nettype wire

//--- verif/lmsu_node.sv
// far-side lin node model: drives the shared bus as a slave transmitter
// assumes a bus pull-up, so a released bus reads high
`timescale 1ns/1ps
`default_nettype none
module lmsu_node (
    input wire logic clk,
    input wire logic tx_out,
    output logic rx_in
);
    // ------------------------------------------------------------
    // wired-and bus with transceiver echo
    // ------------------------------------------------------------
    logic drive = 1'b1;
    // echo means the port hears its own header as well as this node
    assign rx_in = tx_out & drive;
    task automatic send(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            drive <= f[i];
            repeat (bt - 1) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the lin master/slave port core
// assumes lmsu_pkg, lmsu_core and the node model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // clock, pins, counters
    // ------------------------------------------------------------
    localparam int BT = 16; // divisor 0: sixteen clocks a bit, keeps the run short
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] rdata;
    logic tx_out;
    logic rx_in;
    logic irq;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    lmsu_core uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .rx_in(rx_in), .tx_out(tx_out), .irq(irq));
    lmsu_node node (.clk(clk), .tx_out(tx_out), .rx_in(rx_in));
    // ------------------------------------------------------------
    // reporting and compares
    // ------------------------------------------------------------
    task automatic results();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches = mismatches + 1;
            results();
        end
    end
    // ------------------------------------------------------------
    // register port and line sampling
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    // waits for a start edge, then samples n bits at mid-bit; ends mid last bit
    task automatic samp(input int n, output logic [39:0] v);
        int k;
        k = 0;
        v = '0;
        // look just after each edge so the registered pin has settled
        while (tx_out !== 1'b0 && k < 4000) begin
            @(posedge clk);
            #1 k++;
        end
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            #1 v[i] = tx_out;
            if (i < n - 1) repeat (BT) @(posedge clk);
        end
    endtask
    function automatic logic [7:0] add(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[7:0] + {7'h0, t[8]};
    endfunction
    function automatic logic [15:0] ctrl(input logic enh);
        return {12'h0, lmsu_pkg::MODE_LIN} | (16'h1 << lmsu_pkg::C_TX_PATH_ENABLE)
            | (16'h1 << lmsu_pkg::C_RX_PATH_ENABLE) | (16'h1 << lmsu_pkg::C_ON)
            | ({15'h0, enh} << lmsu_pkg::C_CSM);
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [15:0] d;
        rd(lmsu_pkg::A_CTRL, d);
        chk_word(d, lmsu_pkg::CTRL_RST);
        rd(lmsu_pkg::A_IFLAG, d);
        chk_word(d, 16'h0000);
        rd(4'hf, d);
        chk_word(d, 16'h0000);
        @(posedge clk);
        #1 chk_word(rdata, 16'h0000);
        chk_bit(tx_out, 1'b1);
        chk_bit(irq, 1'b0);
    endtask
    task automatic t_header(input logic [7:0] pid);
        logic [39:0] v;
        logic [35:0] e;
        logic [15:0] d;
        e = {2'b11, 1'b1, pid, 1'b0, 1'b1, 8'h55, 1'b0, 1'b1, 13'h0};
        wr(lmsu_pkg::A_HDR, {8'h0, pid});
        samp(36, v);
        chk_word(v[15:0], e[15:0]);
        chk_word(v[31:16], e[31:16]);
        chk_word({12'h0, v[35:32]}, {12'h0, e[35:32]});
        rd(lmsu_pkg::A_IFLAG, d);
        chk_bit(d[lmsu_pkg::I_HDR], 1'b1);
    endtask
    task automatic t_irq();
        logic [15:0] d;
        wr(lmsu_pkg::A_CTRL, ctrl(1'b0));
        t_header(8'h3c);
        chk_bit(irq, 1'b0);
        wr(lmsu_pkg::A_IMASK, 16'h1 << lmsu_pkg::I_HDR);
        chk_bit(irq, 1'b1);
        wr(lmsu_pkg::A_IFLAG, 16'h1 << lmsu_pkg::I_HDR);
        chk_bit(irq, 1'b0);
        wr(lmsu_pkg::A_IMASK, 16'h0000);
        // nobody answered: software lets its window lapse, then a new header
        repeat (20 * BT) @(posedge clk);
        t_header(8'h3c);
        wr(lmsu_pkg::A_IFLAG, 16'h000f);
    endtask
    task automatic t_txresp(input logic enh, input logic [7:0] pid, input logic [7:0] a,
        input logic [7:0] b);
        logic [39:0] v;
        logic [15:0] d;
        logic [7:0] s;
        s = add(add(enh ? pid : 8'h00, a), b);
        wr(lmsu_pkg::A_CTRL, ctrl(enh));
        t_header(pid);
        wr(lmsu_pkg::A_TXD, {8'h0, a});
        samp(10, v);
        chk_word(v[15:0], {6'h0, 1'b1, a, 1'b0});
        wr(lmsu_pkg::A_TXD, {8'h0, b});
        samp(10, v);
        chk_word(v[15:0], {6'h0, 1'b1, b, 1'b0});
        samp(10, v);
        chk_word(v[15:0], {6'h0, 1'b1, ~s, 1'b0});
        repeat (BT) @(posedge clk);
        rd(lmsu_pkg::A_IFLAG, d);
        chk_bit(d[lmsu_pkg::I_RSP], 1'b1);
        chk_bit(d[lmsu_pkg::I_CERR], 1'b0);
        wr(lmsu_pkg::A_IFLAG, 16'h000f);
    endtask
    task automatic t_rxresp(input logic enh, input logic [7:0] pid, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] bad);
        logic [15:0] d;
        logic [7:0] c;
        c = ~add(add(enh ? pid : 8'h00, a), b) ^ bad;
        wr(lmsu_pkg::A_CTRL, ctrl(enh));
        t_header(pid);
        node.send(a, BT);
        node.send(b, BT);
        node.send(c, BT);
        repeat (BT) @(posedge clk);
        rd(lmsu_pkg::A_IFLAG, d);
        chk_bit(d[lmsu_pkg::I_CERR], bad != 8'h00);
        rd(lmsu_pkg::A_RXD, d);
        chk_word(d, {8'h0, c});
        wr(lmsu_pkg::A_IMASK, 16'h1 << lmsu_pkg::I_CERR);
        chk_bit(irq, bad != 8'h00);
        wr(lmsu_pkg::A_IFLAG, 16'h000f);
        wr(lmsu_pkg::A_IMASK, 16'h0000);
        chk_bit(irq, 1'b0);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        wr(lmsu_pkg::A_BAUD, 16'h0000);
        wr(lmsu_pkg::A_RLEN, 16'h0002);
        t_irq();
        t_txresp(1'b0, 8'h3c, 8'h81, 8'hc3);
        t_txresp(1'b1, 8'h97, 8'hfe, 8'h42);
        t_rxresp(1'b0, 8'h3c, 8'h5a, 8'hf0, 8'h00);
        t_rxresp(1'b1, 8'h97, 8'hff, 8'h80, 8'h00);
        t_rxresp(1'b1, 8'h97, 8'h12, 8'h34, 8'h01);
        results();
    end
endmodule
`default_nettype wire
